// File: cocr_defines.svh
/*
 * constants for the charger option control register bank: command codes,
 * bit positions, field positions and reset values.
 * assumes it is included by the design, host and bench files by bare name.
 */
`ifndef COCR_DEFINES_SVH
`define COCR_DEFINES_SVH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define COCR_CMD_OPT3          8'h32
`define COCR_CMD_HOT0          8'h33

// ----------------------------------------------------------------------
// control register bit positions
// ----------------------------------------------------------------------
`define COCR_BIT_HIGHZ         15
`define COCR_BIT_RESTORE       14
`define COCR_BIT_REMEASURE     13
`define COCR_BIT_REVERSE       12
`define COCR_BIT_OPTIMIZER     11
`define COCR_BIT_BATSW_OFF     1
`define COCR_BIT_PMON_SEL      0

// ----------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------
`define COCR_OPT3_RESET        16'h0000
`define COCR_OPT3_MASK         16'hf803
`define COCR_HOT0_RESET        16'h4a54
`define COCR_HOT0_MASK         16'hfefe

// ----------------------------------------------------------------------
// alert option field positions
// ----------------------------------------------------------------------
`define COCR_HOT_ILIM2_MSB     15
`define COCR_HOT_ILIM2_LSB     11
`define COCR_HOT_CRIT_MSB      10
`define COCR_HOT_CRIT_LSB      9
`define COCR_HOT_VSYS_MSB      7
`define COCR_HOT_VSYS_LSB      6
`define COCR_HOT_EXT           5
`define COCR_HOT_WIDTH_MSB     4
`define COCR_HOT_WIDTH_LSB     3
`define COCR_HOT_CLEAR         2
`define COCR_HOT_INOM          1

`endif

// File: cocr_pkg.sv
/*
 * types for the charger option control register bank.
 * assumes cocr_defines.svh is available on the include path.
 */
package cocr_pkg;
   // ----------------------------------------------------------------------
   // host register port request
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic        wr;                // one-cycle write strobe
      logic        rd;                // one-cycle read strobe
      logic [7:0]  cmd;               // command code
      logic [15:0] wdata;             // write word
   } cocr_req_t;

   // ----------------------------------------------------------------------
   // decoded controls driven to the power stage
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic highz_active;             // device in high-impedance mode
      logic regulator_on;             // internal regulator enabled
      logic system_from_battery;      // system powered from battery
      logic battery_switch_on;        // battery switch closed
      logic converter_enable;         // converter allowed to run
      logic remeasure_active;         // threshold measurement requested
      logic reverse_supply_active;    // bus supplied from battery
      logic input_current_optimizer;  // optimizer algorithm running
      logic system_power_monitor_sel; // 1: discharge power only
   } cocr_ctl_t;

   // measurement sequencer states
   typedef enum logic [1:0] {
      COCR_IDLE    = 2'b00,
      COCR_MEASURE = 2'b01,
      COCR_RESTART = 2'b10
   } cocr_state_t;
endpackage

// File: cocr_regs.sv
/*
 * charger option control register bank: the option-three control register
 * and the processor-hot option register, with their control outputs.
 * assumes a host-side bus engine that delivers decoded word accesses as
 * one-cycle strobes synchronous to clk, and analog status as levels.
 */
`timescale 1ns/10ps
`include "cocr_defines.svh"

module cocr_regs
(
   input  wire logic             clk,               // 100 MHz clock
   input  wire logic             reset,             // sync, active high
   input  wire cocr_pkg::cocr_req_t req,            // host access strobe
   input  wire logic             bus_above_uvlo,    // bus supply valid
   input  wire logic             reverse_pin,       // reverse enable pin
   input  wire logic             measure_done,      // threshold measured
   input  wire logic [15:0]      voltage_limit_in,  // limit write data
   input  wire logic             voltage_limit_wr,  // limit write strobe
   output logic [15:0]           rdata,             // read word
   output logic                  rvalid,            // read answer pulse
   output logic                  cmd_error,         // unmapped access
   output logic [15:0]           input_voltage_limit, // kept on restore
   output cocr_pkg::cocr_ctl_t   ctl                // power stage controls
);
   import cocr_pkg::*;

   // ----------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------
   logic [15:0]  opt3;                 // option-three control register
   logic [15:0]  hot0;                 // processor-hot option register
   cocr_state_t  state;                // measurement sequencer
   cocr_ctl_t    next_ctl;             // decoded controls
   logic         wr_opt3;              // write to control register
   logic         wr_hot0;              // write to alert register
   logic         restore;              // restore strobe from host

   // access decode
   assign wr_opt3 = req.wr && (req.cmd == `COCR_CMD_OPT3);
   assign wr_hot0 = req.wr && (req.cmd == `COCR_CMD_HOT0);
   assign restore = wr_opt3 && req.wdata[`COCR_BIT_RESTORE];

   // ----------------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------------
   // restore and reset both land on defaults; the restore bit is never
   // stored, so it reads back zero once the one-cycle reset is done
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         opt3 <= `COCR_OPT3_RESET;
      end
      else if (restore)
      begin
         opt3 <= `COCR_OPT3_RESET;
      end
      else if (wr_opt3)
      begin
         // reserved bits are dropped, so stray ones never read back
         opt3 <= req.wdata & `COCR_OPT3_MASK;
         opt3[`COCR_BIT_RESTORE] <= 1'b0;
      end
      else if (state == COCR_MEASURE && measure_done)
      begin
         opt3[`COCR_BIT_REMEASURE] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // processor-hot option register; field behaviour lives elsewhere
   // ----------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset || restore)
      begin
         hot0 <= `COCR_HOT0_RESET;
      end
      else if (wr_hot0)
      begin
         hot0 <= req.wdata & `COCR_HOT0_MASK;
      end
   end

   // ----------------------------------------------------------------------
   // input voltage limit; survives a restore, only hard reset clears it
   // ----------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         input_voltage_limit <= 16'h0000;
      end
      else if (voltage_limit_wr)
      begin
         input_voltage_limit <= voltage_limit_in;
      end
   end

   // ----------------------------------------------------------------------
   // measurement sequencer
   // ----------------------------------------------------------------------
   // restart takes one cycle so the converter enable rises only after
   // the remeasure bit has visibly dropped
   always_ff @(posedge clk)
   begin
      if (reset || restore)
      begin
         state <= COCR_IDLE;
      end
      else
      begin
         case (state)
            COCR_IDLE:
            begin
               if (opt3[`COCR_BIT_REMEASURE])
               begin
                  state <= COCR_MEASURE;
               end
            end
            COCR_MEASURE:
            begin
               if (measure_done)
               begin
                  state <= COCR_RESTART;
               end
            end
            COCR_RESTART:
            begin
               state <= COCR_IDLE;
            end
            default:
            begin
               state <= COCR_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // control decode
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_ctl = '0;
      next_ctl.highz_active = opt3[`COCR_BIT_HIGHZ];
      // with bus supply present the regulator stays up in high-z
      next_ctl.regulator_on = !opt3[`COCR_BIT_HIGHZ] || bus_above_uvlo;
      next_ctl.system_from_battery = opt3[`COCR_BIT_HIGHZ];
      next_ctl.battery_switch_on = !(opt3[`COCR_BIT_HIGHZ]
                                   && opt3[`COCR_BIT_BATSW_OFF]);
      next_ctl.remeasure_active = opt3[`COCR_BIT_REMEASURE];
      next_ctl.converter_enable = !opt3[`COCR_BIT_HIGHZ]
                                  && !opt3[`COCR_BIT_REMEASURE]
                                  && (state == COCR_IDLE);
      next_ctl.reverse_supply_active = opt3[`COCR_BIT_REVERSE]
                                       && reverse_pin;
      next_ctl.input_current_optimizer = opt3[`COCR_BIT_OPTIMIZER];
      next_ctl.system_power_monitor_sel = opt3[`COCR_BIT_PMON_SEL];
   end

   // controls registered so every output comes from a flip-flop
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctl <= '0;
      end
      else
      begin
         ctl <= next_ctl;
      end
   end

   // ----------------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rdata     <= 16'h0000;
         rvalid    <= 1'b0;
         cmd_error <= 1'b0;
      end
      else
      begin
         rvalid    <= req.rd;
         cmd_error <= (req.rd || req.wr) && (req.cmd != `COCR_CMD_OPT3)
                      && (req.cmd != `COCR_CMD_HOT0);
         if (req.rd)
         begin
            case (req.cmd)
               `COCR_CMD_OPT3: rdata <= opt3;
               `COCR_CMD_HOT0: rdata <= hot0;
               default:        rdata <= 16'h0000; // unmapped reads zero
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   highz_reset_a: assert property (@(posedge clk)
      $fell(reset) |-> !opt3[`COCR_BIT_HIGHZ])
      else $error("highz enable not zero after reset");
   highz_out_a: assert property (@(posedge clk) disable iff (reset)
      wr_opt3 && !restore |=> ##1 ctl.highz_active == $past(req.wdata[15], 2))
      else $error("highz output does not follow write");
   regulator_a: assert property (@(posedge clk) disable iff (reset)
      opt3[15] && bus_above_uvlo |=> ctl.regulator_on
      && ctl.system_from_battery)
      else $error("regulator off in highz with bus supply");
   restore_a: assert property (@(posedge clk) disable iff (reset)
      restore && !voltage_limit_wr
      |=> opt3 == `COCR_OPT3_RESET && hot0 == `COCR_HOT0_RESET
      && $stable(input_voltage_limit))
      else $error("restore failed");
   restore_clear_a: assert property (@(posedge clk)
      !opt3[`COCR_BIT_RESTORE])
      else $error("restore bit stored");
   conv_off_a: assert property (@(posedge clk) disable iff (reset)
      opt3[13] |=> !ctl.converter_enable)
      else $error("converter on during measurement");
   measure_end_a: assert property (@(posedge clk) disable iff (reset)
      state == COCR_MEASURE && measure_done && !req.wr
      |=> !opt3[13] ##1 state == COCR_IDLE ##1 ctl.converter_enable
      || opt3[15] || opt3[13])
      else $error("measurement end did not restart converter");
   reverse_a: assert property (@(posedge clk) disable iff (reset)
      ctl.reverse_supply_active |-> $past(opt3[12]) && $past(reverse_pin))
      else $error("reverse supply without bit and pin");
   batsw_a: assert property (@(posedge clk) disable iff (reset)
      opt3[15] && opt3[1] |=> !ctl.battery_switch_on)
      else $error("battery switch on when ordered off");
   hot_reset_a: assert property (@(posedge clk)
      $fell(reset) |-> hot0 == `COCR_HOT0_RESET)
      else $error("alert register reset value wrong");
   read_a: assert property (@(posedge clk) disable iff (reset)
      req.rd && req.cmd == `COCR_CMD_OPT3 |=> rvalid && rdata == $past(opt3))
      else $error("control read wrong");

   // ----------------------------------------------------------------------
   // field and decode checks
   // ----------------------------------------------------------------------
   // controls lag a write by two edges: one to store the word, one more
   // because ctl is registered; the next two checks look that far ahead and
   // take the written bit from two edges back
   optimizer_a: assert property (@(posedge clk) disable iff (reset)
      wr_opt3 && !restore |=> ##1 ctl.input_current_optimizer
      == $past(req.wdata[`COCR_BIT_OPTIMIZER], 2))
      else $error("optimizer enable does not follow write");
   // monitor select is a plain stored bit, passed on unchanged
   pmon_sel_a: assert property (@(posedge clk) disable iff (reset)
      wr_opt3 && !restore |=> ##1 ctl.system_power_monitor_sel
      == $past(req.wdata[`COCR_BIT_PMON_SEL], 2))
      else $error("monitor select does not follow write");
   // both the bit and the pin must be up; reverse_a covers the converse
   reverse_on_a: assert property (@(posedge clk) disable iff (reset)
      opt3[`COCR_BIT_REVERSE] && reverse_pin |=> ctl.reverse_supply_active)
      else $error("reverse supply off with bit and pin set");
   // without bus supply high-z shuts the regulator to save current
   regulator_off_a: assert property (@(posedge clk) disable iff (reset)
      opt3[`COCR_BIT_HIGHZ] && !bus_above_uvlo |=> !ctl.regulator_on)
      else $error("regulator on in highz without bus supply");
   // a fresh remeasure request leaves idle on the next edge
   measure_start_a: assert property (@(posedge clk) disable iff (reset)
      state == COCR_IDLE && opt3[`COCR_BIT_REMEASURE] && !restore
      |=> state == COCR_MEASURE)
      else $error("remeasure request not taken");
   // alert register stores the written word less its reserved bits
   hot_write_a: assert property (@(posedge clk) disable iff (reset)
      wr_hot0 |=> hot0 == ($past(req.wdata) & `COCR_HOT0_MASK))
      else $error("alert register write lost");
   // unmapped commands flag an error and leave the alert register alone
   unmapped_a: assert property (@(posedge clk) disable iff (reset)
      (req.rd || req.wr) && req.cmd != `COCR_CMD_OPT3
      && req.cmd != `COCR_CMD_HOT0 |=> cmd_error && $stable(hot0))
      else $error("unmapped access not flagged");

   highz_c:   cover property (@(posedge clk) ctl.highz_active);
   measure_c: cover property (@(posedge clk) state == COCR_RESTART);
   reverse_c: cover property (@(posedge clk) ctl.reverse_supply_active);
   restore_c: cover property (@(posedge clk) restore);
   unmapped_c: cover property (@(posedge clk) cmd_error);
endmodule // cocr_regs

// File: cocr_host.sv
/*
 * host model for the charger option control register bank: issues word
 * writes and reads as one-cycle strobes and collects the answers.
 * assumes clk at 100 mhz and that the bench calls its tasks in sequence.
 */
`timescale 1ns/10ps
`include "cocr_defines.svh"

module cocr_host
(
   input  wire logic             clk,       // bank clock
   input  wire logic [15:0]      rdata,     // read word from bank
   input  wire logic             rvalid,    // read answer pulse
   input  wire logic             cmd_error, // unmapped access pulse
   output cocr_pkg::cocr_req_t   req        // access strobe to bank
);
   import cocr_pkg::*;

   // ----------------------------------------------------------------------
   // idle state: strobes low, address and data toggled so stale values
   // never look valid to the bank
   // ----------------------------------------------------------------------
   initial req = '0;

   // drop a finished request, inverting the address and data lines
   task automatic release_req();
      req.wr    = 1'b0;
      req.rd    = 1'b0;
      req.cmd   = ~req.cmd;
      req.wdata = ~req.wdata;
   endtask

   // one word write; reserved bits always go out as zero
   task automatic write_word(input logic [7:0] c, input logic [15:0] d,
                             output logic err);
      logic [15:0] m;
      m = (c == `COCR_CMD_OPT3) ? `COCR_OPT3_MASK :
          (c == `COCR_CMD_HOT0) ? `COCR_HOT0_MASK : 16'hffff;
      @(posedge clk);
      #1;
      req.wr    = 1'b1;
      req.cmd   = c;
      req.wdata = d & m;
      @(posedge clk);
      #1;
      err = cmd_error;
      release_req();
   endtask

   // one word read; answer sampled in the cycle the pulse stands
   task automatic read_word(input logic [7:0] c, output logic [15:0] d,
                            output logic err);
      @(posedge clk);
      #1;
      req.rd  = 1'b1;
      req.cmd = c;
      @(posedge clk);
      #1;
      d   = rvalid ? rdata : 16'hxxxx;
      err = cmd_error;
      release_req();
   endtask
endmodule // cocr_host

// File: tb_top.sv
/*
 * self-checking bench for the charger option control register bank.
 * assumes cocr_regs, cocr_host and cocr_pkg are compiled before it.
 */
`timescale 1ns/10ps
`include "cocr_defines.svh"

`define CHK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) \
      begin \
         error_cnt++; \
         $display("mismatch at %0t got %h exp %h", $time, got, exp); \
      end \
   end

module tb_top;
   import cocr_pkg::*;

   // ----------------------------------------------------------------------
   // signals and model state
   // ----------------------------------------------------------------------
   logic          clk = 1'b0;      // 100 mhz clock
   logic          reset = 1'b1;    // sync reset
   cocr_req_t     req;             // host strobes
   logic          uvlo_ok = 1'b0;  // bus supply valid
   logic          rev_pin = 1'b0;  // reverse enable pin
   logic          done = 1'b0;     // measurement finished
   logic [15:0]   lim_in = '0;     // limit load data
   logic          lim_wr = 1'b0;   // limit load strobe
   logic [15:0]   rdata;           // read word
   logic          rvalid;          // read pulse
   logic          cmd_error;       // unmapped pulse
   logic [15:0]   lim_out;         // stored limit
   cocr_ctl_t     ctl;             // decoded controls
   logic [15:0]   m_opt3, m_hot0, m_lim, d; // model registers, read word
   logic          err;             // error flag of last access
   int            error_cnt = 0;   // mismatches
   int            tests_run = 0;   // comparisons

   always #5 clk = ~clk;

   cocr_regs u_cocr_regs (.clk(clk), .reset(reset), .req(req),
      .bus_above_uvlo(uvlo_ok), .reverse_pin(rev_pin), .measure_done(done),
      .voltage_limit_in(lim_in), .voltage_limit_wr(lim_wr), .rdata(rdata),
      .rvalid(rvalid), .cmd_error(cmd_error),
      .input_voltage_limit(lim_out), .ctl(ctl));

   cocr_host u_cocr_host (.clk(clk), .rdata(rdata), .rvalid(rvalid),
      .cmd_error(cmd_error), .req(req));

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // let the decode settle two edges after a write
   task automatic settle();
      @(posedge clk);
      @(posedge clk);
      #1;
   endtask

   // compare the decoded controls with the model register
   task automatic check_ctl();
      logic hz;
      hz = m_opt3[15];
      `CHK(ctl.highz_active, hz)
      `CHK(ctl.reverse_supply_active, m_opt3[12] & rev_pin)
      `CHK(ctl.input_current_optimizer, m_opt3[11])
      `CHK(ctl.system_power_monitor_sel, m_opt3[0])
      `CHK(ctl.remeasure_active, m_opt3[13])
      if (hz)
      begin
         `CHK(ctl.converter_enable, 1'b0)
         `CHK(ctl.battery_switch_on, ~m_opt3[1])
         if (uvlo_ok)
         begin
            `CHK({ctl.regulator_on, ctl.system_from_battery}, 2'b11)
         end
         else
         begin
            `CHK(ctl.regulator_on, 1'b0)
         end
      end
      else
      begin
         `CHK(ctl.converter_enable, 1'b1)
         `CHK(ctl.battery_switch_on, 1'b1)
         `CHK({ctl.regulator_on, ctl.system_from_battery}, 2'b10)
      end
   endtask

   // read both registers and compare with the model
   task automatic check_regs();
      u_cocr_host.read_word(`COCR_CMD_OPT3, d, err);
      `CHK(d, m_opt3)
      u_cocr_host.read_word(`COCR_CMD_HOT0, d, err);
      `CHK(d, m_hot0)
      `CHK(lim_out, m_lim)
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // watchdog: the whole run needs a few hundred cycles
   initial
   begin
      #200000;
      error_cnt++;
      end_sim();
   end

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      void'($urandom(85762));
      repeat (2) @(posedge clk);
      #1;
      reset = 1'b0;
      m_opt3 = `COCR_OPT3_RESET;
      m_hot0 = `COCR_HOT0_RESET;
      m_lim  = 16'h0000;
      check_regs();
      settle();
      `CHK(ctl.reverse_supply_active, 1'b0)
      $display("test reset_values done");
      // random control words, pins and alert settings
      repeat (24)
      begin
         uvlo_ok = 1'($urandom);
         rev_pin = 1'($urandom);
         m_opt3 = 16'($urandom) & `COCR_OPT3_MASK & 16'h9fff;
         m_hot0 = 16'($urandom) & `COCR_HOT0_MASK;
         u_cocr_host.write_word(`COCR_CMD_HOT0, m_hot0, err);
         u_cocr_host.write_word(`COCR_CMD_OPT3, m_opt3, err);
         `CHK(err, 1'b0)
         settle();
         check_ctl();
         check_regs();
      end
      $display("test random_controls done");
      // unmapped command: write dropped, read zero, error pulse
      u_cocr_host.write_word(8'h40, 16'hffff, err);
      `CHK(err, 1'b1)
      u_cocr_host.read_word(8'h40, d, err);
      `CHK({err, d}, {1'b1, 16'h0000})
      check_regs();
      $display("test unmapped done");
      // restore defaults keeps the voltage limit
      @(posedge clk);
      #1;
      lim_in = 16'($urandom);
      lim_wr = 1'b1;
      @(posedge clk);
      #1;
      lim_wr = 1'b0;
      m_lim = lim_in;
      u_cocr_host.write_word(`COCR_CMD_OPT3, 16'h4000, err);
      settle();
      m_opt3 = `COCR_OPT3_RESET;
      m_hot0 = `COCR_HOT0_RESET;
      check_regs();
      $display("test restore done");
      // threshold remeasure holds the converter off until done
      u_cocr_host.write_word(`COCR_CMD_OPT3, 16'h2000, err);
      settle();
      `CHK({ctl.converter_enable, ctl.remeasure_active}, 2'b01)
      m_opt3 = 16'h2000;
      check_regs();
      done = 1'b1;
      @(posedge clk);
      #1;
      done = 1'b0;
      m_opt3 = `COCR_OPT3_RESET;
      for (int i = 0; i < 10 && ctl.converter_enable !== 1'b1; i++)
      begin
         @(posedge clk);
         #1;
      end
      `CHK({ctl.converter_enable, ctl.remeasure_active}, 2'b10)
      check_regs();
      $display("test remeasure done");
      // mid-run reset from a high-z state brings every default back
      u_cocr_host.write_word(`COCR_CMD_OPT3, 16'h8003, err);
      reset = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      reset = 1'b0;
      m_opt3 = `COCR_OPT3_RESET;
      m_hot0 = `COCR_HOT0_RESET;
      m_lim  = 16'h0000;
      settle();
      check_ctl();
      check_regs();
      $display("test mid_reset done");
      end_sim();
   end
endmodule // tb_top
